/* core/nv_suspend_defines.svh */
// Operation
// R1: Suspend opcode pauses running program or erase.
// R2: Program suspend blocks status writes, erases, programs.
// R3: Erase suspend blocks status writes and erases.
// R4: Suspend valid only while program/erase runs.
// R5: Suspend entry completes within maximum suspend latency.
// R6: Write enable accepted during erase suspend only.
// R7: Status register reads accepted in any suspend.
// R8: Extended address reads/writes accepted in suspend.
// R9: All array read opcodes accepted in suspend.
// R10: Page programs accepted only during erase suspend.
// R11: Resume opcode accepted while an operation suspended.
// R12: Enable-reset and reset accepted at any time.
// R13: Suspend needs paused flag 0, busy 1.
// R14: Paused flag sets at once, busy clears later.
// R15: Resume needs paused flag 1 and busy 0.
// R16: Resume clears paused flag, sets busy quickly.
// R17: Software reset aborts work, clears suspend state.
// R18: Suspend/resume are lone 8-bit frames, executed on deselect.
// R19: Separate paused flags; unlisted opcodes ignored.
`ifndef NV_SUSPEND_DEFINES_SVH
`define NV_SUSPEND_DEFINES_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS    10
`define SUSPEND_MAX_NS   20000
`define RESUME_MAX_NS    200
`define RESUME_CYCLES    (`RESUME_MAX_NS / `CLK_PERIOD_NS)
`define OPCODE_BITS      8
`define BIT_COUNT_W      4
`define TIMER_W          16

// ----------------------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------------------
`define OP_PAUSE         8'h75
`define OP_CONTINUE      8'h7A
`define OP_WREN          8'h06
`define OP_RDSR1         8'h05
`define OP_RDSR2         8'h35
`define OP_RDSR3         8'h15
`define OP_RDEAR         8'hC8
`define OP_WREAR         8'hC5
`define OP_READ3         8'h03
`define OP_READ4         8'h13
`define OP_FAST3         8'h0B
`define OP_FAST4         8'h0C
`define OP_DIO3          8'hBB
`define OP_DIO4          8'hBC
`define OP_DOUT3         8'h3B
`define OP_DOUT4         8'h3C
`define OP_QIO3          8'hEB
`define OP_QIO4          8'hEC
`define OP_QOUT3         8'h6B
`define OP_QOUT4         8'h6C
`define OP_PP3           8'h02
`define OP_PP4           8'h12
`define OP_QPP3          8'h32
`define OP_QPP4          8'h34
`define OP_RST_ENABLE    8'h66
`define OP_RST           8'h99

`endif

/* core/nv_suspend_pkg.sv */
package nv_suspend_pkg;

  typedef logic [7:0] opcode_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PROG,
    ST_ERASE,
    ST_ENTER,
    ST_SUSPENDED,
    ST_NESTED
  } seq_state_t;

endpackage

/* core/nv_suspend_ctrl.sv */
`timescale 1ns/1ns
`include "nv_suspend_defines.svh"

module nv_suspend_ctrl #(
  parameter int SUSPEND_MAX_NS = `SUSPEND_MAX_NS
) (
  // Clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     arst_n,
  // Serial link pins
  input  wire logic                     sclk,
  input  wire logic                     csN,
  input  wire logic                     si,
  // Engine handshake
  input  wire logic                     programStart,
  input  wire logic                     eraseStart,
  input  wire logic                     engineDone,
  input  wire logic                     engineHalted,
  output logic                          engineHold,
  output logic                          engineAbort,
  // Status flags
  output logic                          operation_in_progress_flag,
  output logic                          program_paused_flag,
  output logic                          erase_paused_flag,
  // Command forwarding
  output logic                          cmdValid,
  output nv_suspend_pkg::opcode_t       cmdOpcode,
  output logic                          cmdRejected
);

  localparam int SUSPEND_CYCLES_I = SUSPEND_MAX_NS / `CLK_PERIOD_NS;
  localparam logic [`TIMER_W-1:0] SUSPEND_CYCLES =
    (SUSPEND_CYCLES_I < 1) ? `TIMER_W'(1) : `TIMER_W'(SUSPEND_CYCLES_I);

  // --------------------------------------------------------------------------
  // Opcode filter
  // --------------------------------------------------------------------------
  // An allow list rather than a block list, so opcodes nobody listed stay out during a suspend.
  function automatic logic opAllowed(input nv_suspend_pkg::opcode_t op,
                                     input logic progSus,
                                     input logic eraseSus);
    logic common;
    logic eraseOnly;
    common = 1'b0;
    eraseOnly = 1'b0;
    case (op)
      `OP_RDSR1, `OP_RDSR2, `OP_RDSR3: common = 1'b1;               // see R7
      `OP_RDEAR, `OP_WREAR: common = 1'b1;                          // see R8
      `OP_READ3, `OP_READ4, `OP_FAST3, `OP_FAST4,
      `OP_DIO3, `OP_DIO4, `OP_DOUT3, `OP_DOUT4,
      `OP_QIO3, `OP_QIO4, `OP_QOUT3, `OP_QOUT4: common = 1'b1;      // see R9
      `OP_CONTINUE: common = 1'b1;                                  // see R11
      `OP_RST_ENABLE, `OP_RST: common = 1'b1;                       // see R12
      `OP_WREN: eraseOnly = 1'b1;                                   // see R6
      `OP_PP3, `OP_PP4, `OP_QPP3, `OP_QPP4: eraseOnly = 1'b1;       // see R10
      default: common = 1'b0;
    endcase
    if (!progSus && !eraseSus) begin
      return 1'b1;
    end
    if (progSus) begin
      return common;                                                // see R2
    end
    return common | eraseOnly;                                      // see R3 R19
  endfunction

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  logic [1:0] sclkSync_r;
  logic [1:0] csSync_r;
  logic [1:0] siSync_r;
  logic       sclkPrev_r;
  logic       csPrev_r;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sclkSync_r <= 2'b00;
      csSync_r   <= 2'b11;
      siSync_r   <= 2'b00;
      sclkPrev_r <= 1'b0;
      csPrev_r   <= 1'b1;
    end else begin
      sclkSync_r <= {sclkSync_r[0], sclk};
      csSync_r   <= {csSync_r[0], csN};
      siSync_r   <= {siSync_r[0], si};
      sclkPrev_r <= sclkSync_r[1];
      csPrev_r   <= csSync_r[1];
    end
  end

  logic sclkRise;
  logic frameEnd;
  logic selected;

  assign selected = !csSync_r[1];
  assign sclkRise = selected && sclkSync_r[1] && !sclkPrev_r;
  assign frameEnd = csSync_r[1] && !csPrev_r;

  // --------------------------------------------------------------------------
  // Opcode shifter
  // --------------------------------------------------------------------------
  logic [`BIT_COUNT_W-1:0]  bitCount_r;
  nv_suspend_pkg::opcode_t  shift_r;
  logic                     extraBits_r;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      bitCount_r  <= '0;
      shift_r     <= '0;
      extraBits_r <= 1'b0;
    end else if (frameEnd) begin
      bitCount_r  <= '0;
      extraBits_r <= 1'b0;
    end else if (sclkRise) begin
      if (bitCount_r < `BIT_COUNT_W'(`OPCODE_BITS)) begin
        shift_r    <= {shift_r[6:0], siSync_r[1]};
        bitCount_r <= bitCount_r + `BIT_COUNT_W'(1);
      end else begin
        extraBits_r <= 1'b1;
      end
    end
  end

  logic opcodeDone;
  logic frameIsLone;
  nv_suspend_pkg::opcode_t nextOp;

  assign nextOp      = {shift_r[6:0], siSync_r[1]};
  assign opcodeDone  = sclkRise && (bitCount_r == `BIT_COUNT_W'(`OPCODE_BITS - 1));
  // Only a frame of exactly eight bits may carry a lone command.
  assign frameIsLone = frameEnd && (bitCount_r == `BIT_COUNT_W'(`OPCODE_BITS))
                       && !extraBits_r;                             // see R18

  // --------------------------------------------------------------------------
  // Command gate
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cmdValid    <= 1'b0;
      cmdRejected <= 1'b0;
      cmdOpcode   <= '0;
    end else begin
      cmdValid    <= 1'b0;
      cmdRejected <= 1'b0;
      if (opcodeDone) begin
        cmdOpcode <= nextOp;
        if (opAllowed(nextOp, program_paused_flag, erase_paused_flag)) begin
          cmdValid <= 1'b1;                                         // see R19
        end else begin
          cmdRejected <= 1'b1;                                      // see R2 R3
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Software reset
  // --------------------------------------------------------------------------
  logic resetArmed_r;
  logic softReset;

  assign softReset = frameIsLone && resetArmed_r && (shift_r == `OP_RST);

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      resetArmed_r <= 1'b0;
    end else if (frameEnd) begin
      // Any other frame between the two opcodes disarms the reset.
      resetArmed_r <= frameIsLone && (shift_r == `OP_RST_ENABLE);   // see R12
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      engineAbort <= 1'b0;
    end else begin
      engineAbort <= softReset;                                     // see R17
    end
  end

  // --------------------------------------------------------------------------
  // Suspend and resume sequencer
  // --------------------------------------------------------------------------
  nv_suspend_pkg::seq_state_t state_r;
  logic [`TIMER_W-1:0]        timer_r;
  logic                       pauseCmd;
  logic                       continueCmd;
  logic                       enterDone;

  assign pauseCmd    = frameIsLone && (shift_r == `OP_PAUSE);       // see R1 R18
  assign continueCmd = frameIsLone && (shift_r == `OP_CONTINUE);    // see R11 R18
  // The engine may report its halt early; the timer caps the wait regardless.
  assign enterDone   = engineHalted || (timer_r == SUSPEND_CYCLES - `TIMER_W'(1));

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      timer_r <= '0;
    end else if (state_r == nv_suspend_pkg::ST_ENTER) begin
      timer_r <= timer_r + `TIMER_W'(1);                            // see R5
    end else begin
      timer_r <= '0;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r                    <= nv_suspend_pkg::ST_IDLE;
      operation_in_progress_flag <= 1'b0;
      program_paused_flag        <= 1'b0;
      erase_paused_flag          <= 1'b0;
      engineHold                 <= 1'b0;
    end else if (softReset) begin
      state_r                    <= nv_suspend_pkg::ST_IDLE;        // see R17
      operation_in_progress_flag <= 1'b0;
      program_paused_flag        <= 1'b0;
      erase_paused_flag          <= 1'b0;
      engineHold                 <= 1'b0;
    end else begin
      case (state_r)
        nv_suspend_pkg::ST_IDLE: begin
          if (programStart) begin
            state_r                    <= nv_suspend_pkg::ST_PROG;
            operation_in_progress_flag <= 1'b1;
          end else if (eraseStart) begin
            state_r                    <= nv_suspend_pkg::ST_ERASE;
            operation_in_progress_flag <= 1'b1;
          end
        end
        nv_suspend_pkg::ST_PROG, nv_suspend_pkg::ST_ERASE: begin
          if (engineDone) begin
            state_r                    <= nv_suspend_pkg::ST_IDLE;
            operation_in_progress_flag <= 1'b0;
          end else if (pauseCmd && operation_in_progress_flag) begin // see R4 R13
            state_r    <= nv_suspend_pkg::ST_ENTER;
            engineHold <= 1'b1;
            if (state_r == nv_suspend_pkg::ST_PROG) begin
              program_paused_flag <= 1'b1;                          // see R14
            end else begin
              erase_paused_flag <= 1'b1;                            // see R14
            end
          end
        end
        nv_suspend_pkg::ST_ENTER: begin
          if (enterDone) begin
            state_r                    <= nv_suspend_pkg::ST_SUSPENDED;
            operation_in_progress_flag <= 1'b0;                     // see R5 R14
          end
        end
        nv_suspend_pkg::ST_SUSPENDED: begin
          if (continueCmd && !operation_in_progress_flag) begin     // see R15
            // Busy returns in the next cycle, well inside the resume window.
            state_r                    <= program_paused_flag ?
                                          nv_suspend_pkg::ST_PROG :
                                          nv_suspend_pkg::ST_ERASE;
            program_paused_flag        <= 1'b0;                     // see R16
            erase_paused_flag          <= 1'b0;                     // see R16
            operation_in_progress_flag <= 1'b1;                     // see R16
            engineHold                 <= 1'b0;
          end else if (erase_paused_flag && programStart) begin     // see R10
            state_r                    <= nv_suspend_pkg::ST_NESTED;
            operation_in_progress_flag <= 1'b1;
          end
        end
        nv_suspend_pkg::ST_NESTED: begin
          // A paused flag is already set, so a pause here is ignored.
          if (engineDone) begin                                     // see R13
            state_r                    <= nv_suspend_pkg::ST_SUSPENDED;
            operation_in_progress_flag <= 1'b0;
          end
        end
        default: begin
          state_r <= nv_suspend_pkg::ST_IDLE;
        end
      endcase
    end
  end

endmodule // nv_suspend_ctrl

/* verification/nv_suspend_ctrl_asserts.sv */
`timescale 1ns/1ns
module nv_suspend_ctrl_asserts #(
  parameter int SUSPEND_MAX_NS = 20000
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Watched outputs
  input wire logic engineHold,
  input wire logic engineAbort,
  input wire logic operation_in_progress_flag,
  input wire logic program_paused_flag,
  input wire logic erase_paused_flag,
  input wire logic cmdValid,
  input wire logic cmdRejected
);
  // Entry may wait the full latency in the entry state plus the frame-end step.
  localparam int SusLim = SUSPEND_MAX_NS / 10 + 2;
  logic anyPaused;
  assign anyPaused = program_paused_flag | erase_paused_flag;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  property p_one_flag; !(program_paused_flag && erase_paused_flag); endproperty
  a_one_flag: assert property (p_one_flag) else $error("both paused flags set");
  property p_need_busy; $rose(anyPaused) |-> $past(operation_in_progress_flag); endproperty
  a_need_busy: assert property (p_need_busy) else $error("pause taken while idle");
  property p_busy_drop; $rose(anyPaused) |-> ##[1:SusLim] !operation_in_progress_flag; endproperty
  a_busy_drop: assert property (p_busy_drop) else $error("busy kept after pause");
  property p_resume;
    $fell(anyPaused) && !engineAbort && !$past(engineAbort) |->
      operation_in_progress_flag && !engineHold;
  endproperty
  a_resume: assert property (p_resume) else $error("resume did not restart");
  property p_hold; anyPaused |-> engineHold; endproperty
  a_hold: assert property (p_hold) else $error("engine not held in pause");
  property p_abort; engineAbort |-> ##[0:1] !anyPaused && !operation_in_progress_flag; endproperty
  a_abort: assert property (p_abort) else $error("reset left state");
  property p_abort_pulse; engineAbort |=> !engineAbort; endproperty
  a_abort_pulse: assert property (p_abort_pulse) else $error("abort too long");
  property p_cmd_pulse; cmdValid |=> !cmdValid; endproperty
  a_cmd_pulse: assert property (p_cmd_pulse) else $error("valid too long");
  property p_reject; cmdRejected |-> anyPaused && !cmdValid; endproperty
  a_reject: assert property (p_reject) else $error("reject with no pause");
endmodule // nv_suspend_ctrl_asserts

bind nv_suspend_ctrl nv_suspend_ctrl_asserts #(.SUSPEND_MAX_NS(SUSPEND_MAX_NS)) chkI (
  .ref_clk, .arst_n, .engineHold, .engineAbort, .operation_in_progress_flag,
  .program_paused_flag, .erase_paused_flag, .cmdValid, .cmdRejected
);

/* verification/spi_flash_host.sv */
`timescale 1ns/1ns
module spi_flash_host (
  // Serial link pins
  output logic sclk,
  output logic csN,
  output logic si
);
  initial begin
    sclk = 1'b0;
    csN = 1'b1;
    si = 1'b0;
  end
  // Link clock stands low between frames; delays keep edges off ref_clk edges.
  task automatic send(input nv_suspend_pkg::opcode_t op, input logic extra);
    int n;
    n = extra ? 9 : 8;
    csN = 1'b0;
    #63;
    for (int i = 0; i < n; i++) begin
      si = (i < 8) ? op[7-i] : ~op[0];
      #61 sclk = 1'b1;
      #64 sclk = 1'b0;
    end
    #61 csN = 1'b1;
    si = ~si;
    #300;
  endtask
endmodule // spi_flash_host

/* verification/flash_program_erase_suspend_resume_tb.sv */
`timescale 1ns/1ns
`include "nv_suspend_defines.svh"
module flash_program_erase_suspend_resume_tb;
  logic ref_clk = 0, arst_n = 0, programStart = 0, eraseStart = 0;
  logic engineDone = 0, engineHalted = 0, gotV, gotR, gotA;
  logic sclk, csN, si, engineHold, engineAbort, cmdValid, cmdRejected;
  logic operation_in_progress_flag, program_paused_flag, erase_paused_flag;
  nv_suspend_pkg::opcode_t cmdOpcode;
  int fails = 0, samples_checked = 0;
  nv_suspend_pkg::opcode_t progNo[15] = '{8'h01, 8'h31, 8'h11, 8'h44, 8'h42, 8'h20,
    8'h52, 8'hD8, 8'hC7, 8'h60, 8'h02, 8'h32, 8'h12, 8'h34, 8'h06};
  nv_suspend_pkg::opcode_t eraseNo[9] = '{8'h01, 8'h31, 8'h11, 8'h44, 8'h20, 8'h52,
    8'hD8, 8'hC7, 8'h60};
  nv_suspend_pkg::opcode_t bothOk[17] = '{8'h05, 8'h35, 8'h15, 8'hC8, 8'hC5, 8'h03,
    8'h13, 8'h0B, 8'h0C, 8'hBB, 8'hBC, 8'h3B, 8'h3C, 8'hEB, 8'hEC, 8'h6B, 8'h6C};
  nv_suspend_pkg::opcode_t eraseOk[5] = '{8'h06, 8'h02, 8'h12, 8'h32, 8'h34};
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (cmdValid) gotV <= 1'b1;
    if (cmdRejected) gotR <= 1'b1;
    if (engineAbort) gotA <= 1'b1;
  end
  // Short latency parameter keeps each suspend entry to a few tens of cycles.
  nv_suspend_ctrl #(.SUSPEND_MAX_NS(200)) dut (
    .ref_clk, .arst_n, .sclk, .csN, .si, .programStart, .eraseStart, .engineDone,
    .engineHalted, .engineHold, .engineAbort, .operation_in_progress_flag,
    .program_paused_flag, .erase_paused_flag, .cmdValid, .cmdOpcode, .cmdRejected
  );
  spi_flash_host host (.sclk, .csN, .si);
  // ----
  // Shared tasks
  // ----
  task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic pulse(ref logic s);
    @(negedge ref_clk) s = 1'b1;
    @(negedge ref_clk) s = 1'b0;
  endtask
  task frame(input nv_suspend_pkg::opcode_t op, input logic extra);
    @(negedge ref_clk);
    gotV = 1'b0;
    gotR = 1'b0;
    gotA = 1'b0;
    host.send(op, extra);
    @(negedge ref_clk);
  endtask
  task flags(input logic [2:0] exp, input string what);
    chk(what, {5'h00, exp}, {5'h00, operation_in_progress_flag, program_paused_flag,
      erase_paused_flag});
  endtask
  task filt(input nv_suspend_pkg::opcode_t op, input logic ok);
    frame(op, 1'b0);
    chk("cmdValid", {7'h00, ok}, {7'h00, gotV});
    chk("cmdRejected", {7'h00, ~ok}, {7'h00, gotR});
    chk("cmdOpcode", op, cmdOpcode);
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ----
  // Scenarios
  // ----
  task t_idle;
    frame(`OP_PAUSE, 1'b0);
    flags(3'b000, "idle pause");
    frame(`OP_CONTINUE, 1'b0);
    flags(3'b000, "idle resume");
    $display("test idle done");
  endtask
  task t_prog;
    pulse(programStart);
    frame(`OP_PAUSE, 1'b1);
    flags(3'b100, "long pause frame");
    frame(`OP_PAUSE, 1'b0);
    pulse(engineHalted);
    flags(3'b010, "program paused");
    chk("engineHold", 8'h01, {7'h00, engineHold});
    frame(`OP_PAUSE, 1'b0);
    flags(3'b010, "second pause");
    foreach (progNo[i]) filt(progNo[i], 1'b0);
    foreach (bothOk[i]) filt(bothOk[i], 1'b1);
    frame(`OP_CONTINUE, 1'b0);
    flags(3'b100, "program resumed");
    chk("engineHold", 8'h00, {7'h00, engineHold});
    pulse(engineDone);
    @(negedge ref_clk);
    flags(3'b000, "program done");
    $display("test program suspend done");
  endtask
  task t_erase;
    pulse(eraseStart);
    frame(`OP_PAUSE, 1'b0);
    flags(3'b001, "erase paused");
    foreach (eraseNo[i]) filt(eraseNo[i], 1'b0);
    foreach (bothOk[i]) filt(bothOk[i], 1'b1);
    foreach (eraseOk[i]) filt(eraseOk[i], 1'b1);
    frame(`OP_RST_ENABLE, 1'b0);
    frame(`OP_RST, 1'b0);
    chk("engineAbort", 8'h01, {7'h00, gotA});
    flags(3'b000, "after reset");
    $display("test erase suspend done");
  endtask
  task t_nested;
    pulse(eraseStart);
    frame(`OP_PAUSE, 1'b0);
    pulse(programStart);
    flags(3'b101, "nested program");
    frame(`OP_PAUSE, 1'b0);
    flags(3'b101, "nested pause");
    pulse(engineDone);
    flags(3'b001, "nested done");
    frame(`OP_CONTINUE, 1'b0);
    flags(3'b100, "erase resumed");
    fork
      frame(`OP_PAUSE, 1'b0);
      begin : earlyHalt
        int n;
        n = 0;
        while (!engineHold && n < 200) begin
          @(negedge ref_clk);
          n++;
        end
        chk("engineHold", 8'h01, {7'h00, engineHold});
        if (!engineHold) tally_and_finish;
        pulse(engineHalted);
        flags(3'b001, "early halt");
      end
    join
    frame(`OP_RST_ENABLE, 1'b0);
    frame(`OP_RDSR1, 1'b0);
    frame(`OP_RST, 1'b0);
    chk("engineAbort", 8'h00, {7'h00, gotA});
    flags(3'b001, "reset disarmed");
    frame(`OP_RST_ENABLE, 1'b0);
    frame(`OP_RST, 1'b0);
    chk("engineAbort", 8'h01, {7'h00, gotA});
    chk("engineHold", 8'h00, {7'h00, engineHold});
    flags(3'b000, "nested reset");
    $display("test nested suspend done");
  endtask
  initial begin
    repeat (4) @(negedge ref_clk);
    arst_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    t_idle;
    t_prog;
    t_erase;
    t_nested;
    tally_and_finish;
  end
endmodule // flash_program_erase_suspend_resume_tb
